// file: logic/cpw_unit.sv
// Capture/compare/PWM unit with its registers on an AHB-Lite slave
// Behaviour
// R1: reset restores registers, pin to input
// R2: control bit 7 enables the unit
// R3: control bit 5 reads output level, read-only
// R4: control bit 6 always reads zero
// R5: alignment bit picks duty layout in PWM
// R6: mode codes 11xx select PWM
// R7: compare pulse/clear-timer, pulse, clear, set
// R8: toggle, toggle and clear timer on match
// R9: capture on 16th, 4th, rise, fall, both
// R10: mode 0000 turns unit off, resets
// R11: time base fields for units one, two
// R12: time base fields for simple units three, four
// R13: capture stores compare timer bytes
// R14: compare uses 16-bit value pair
// R15: right-aligned duty from low, high 1:0
// R16: left-aligned duty from high, low 7:6
// R17: PWM signal offered to on-chip consumers
// R18: PWM timing follows the system clock
// R19: rollover sets output, latches duty buffer
// R20: time base match clears output
// R21: width beyond period leaves output unchanged
// R22: reserved time base code holds output
`timescale 1ns/1ps
`default_nettype none
`include "cpw_consts.svh"
module cpw_unit (
   // Clock, reset, freeze
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // Timers on the system clock
   input wire logic [15:0] COMPARE_TIMER,
   input wire cpw_pkg::cpw_base_t [2:0] TIMER_BASE,
   // Unit pin and capture input
   input wire logic UNIT_PIN_IN,
   output logic UNIT_PIN_OUT,
   output logic UNIT_PIN_OE,
   // Signals to other logic
   output logic COMPARE_CLEAR,
   output logic PWM_SIGNAL,
   output logic [7:0] BASE_SELECT
);
   // ************
   // Mode decode
   // ************
   function automatic logic f_is_pwm(input logic [3:0] m);
      // R6: 11xx is PWM
      return m[3:2] == `CPW_M_PWM_TOP;
   endfunction : f_is_pwm

   function automatic logic f_is_cap(input logic [3:0] m);
      return (m >= `CPW_M_CAP_BOTH) && (m <= `CPW_M_CAP_16);
   endfunction : f_is_cap

   function automatic logic f_is_cmp(input logic [3:0] m);
      return (m[3:2] == 2'b10) || (m == `CPW_M_TGLCLR) || (m == `CPW_M_TGL);
   endfunction : f_is_cmp

   // ************
   // State
   // ************
   cpw_pkg::cpw_ctl_t ctl_r, ctl_nxt;
   logic [7:0] tsel_r, tsel_nxt;
   logic [7:0] low_r, low_nxt;
   logic [7:0] high_r, high_nxt;
   logic out_r, out_nxt;
   logic wr_pend_r;
   logic rd_ctl_r;
   logic [7:0] addr_r;
   logic [31:0] hrdata_r;
   logic hready_r;
   logic pin_oe_r;
   logic cmp_clr_r;
   logic pwm_sig_r;
   logic pulse_r;
   logic mprev_r;
   logic [3:0] pre_r;
   logic sync1_r, sync2_r, sync3_r;
   logic pwm_lvl;

   // ************
   // Bus decode
   // ************
   // Only a one-cycle address phase with hready high is taken
   wire addr_ok = HSEL && HREADY && HTRANS[1];
   wire mapped = (HADDR[31:4] == 28'h0000000) && (HADDR[1:0] == 2'b00);
   wire [7:0] addr_lo = HADDR[7:0];
   wire wr_ctl = wr_pend_r && (addr_r == `CPW_OFS_CONTROL);
   wire wr_tsel = wr_pend_r && (addr_r == `CPW_OFS_TSEL);
   wire wr_low = wr_pend_r && (addr_r == `CPW_OFS_LOW);
   wire wr_high = wr_pend_r && (addr_r == `CPW_OFS_HIGH);
   wire [7:0] wdat = HWDATA[7:0];

   // ************
   // Mode and match
   // ************
   wire [3:0] mode = ctl_r.mode;
   wire en = ctl_r.en;
   wire pwm_on = en && f_is_pwm(mode);
   wire cmp_on = en && f_is_cmp(mode);
   wire cap_on = en && f_is_cap(mode);
   // R14: 16-bit value pair against compare timer
   wire match = cmp_on && (COMPARE_TIMER == {high_r, low_r});
   // Act once per match, not on every cycle the timer dwells there
   wire cmp_hit = match && !mprev_r;

   // Edges seen only after the second synchroniser stage
   wire rise = sync2_r && !sync3_r;
   wire fall = !sync2_r && sync3_r;
   // R9: edge kind per capture mode
   wire edge_hit = cap_on && ((mode == `CPW_M_CAP_BOTH) ? (rise || fall) :
                              (mode == `CPW_M_CAP_FALL) ? fall : rise);
   // R9: prescaled capture on 4th and 16th edge
   wire cap_evt = edge_hit &&
      ((mode == `CPW_M_CAP_4) ? ({2'b00, pre_r[1:0]} == `CPW_PRE_4) :
       (mode == `CPW_M_CAP_16) ? (pre_r == `CPW_PRE_16) : 1'b1);

   // ************
   // PWM time base
   // ************
   // R11: unit one picks its base from bits 1-0
   wire [1:0] base_sel = tsel_r[1:0];
   // R22: reserved code selects nothing
   wire base_ok = base_sel != `CPW_TSEL_RSVD;
   wire cpw_pkg::cpw_base_t base = base_ok ? TIMER_BASE[base_sel] : '0;
   // R5: alignment bit picks the layout
   // R15: right aligned from low and high 1:0
   // R16: left aligned from high and low 7:6
   wire [9:0] duty = ctl_r.fmt ? {high_r, low_r[7:6]} : {high_r[1:0], low_r};

   cpw_pwm u_pwm (
      .clk(CLK),
      .rst(RST),
      .ce(CE),
      .run(pwm_on && base_ok),
      .off(mode == `CPW_M_OFF),
      .base(base),
      .duty(duty),
      .lvl(pwm_lvl)
   );

   // ************
   // Next register values
   // ************
   // R2: enable bit stored from bit 7
   // R3: output bit not writable
   assign ctl_nxt = wr_ctl ? {wdat[`CPW_CTL_EN], wdat[`CPW_CTL_FMT], wdat[3:0]} : ctl_r;
   // R12: all four select fields stored
   assign tsel_nxt = wr_tsel ? wdat : tsel_r;
   // R13: capture beats a write in the same cycle
   assign low_nxt = cap_evt ? COMPARE_TIMER[7:0] : (wr_low ? wdat : low_r);
   assign high_nxt = cap_evt ? COMPARE_TIMER[15:8] : (wr_high ? wdat : high_r);

   // Output level per mode
   always_comb begin
      out_nxt = out_r;
      if (mode == `CPW_M_OFF) begin
         // R10: off forces the output low
         out_nxt = 1'b0;
      end else if (pwm_on) begin
         out_nxt = pwm_lvl;
      end else if (cmp_on && pulse_r) begin
         // R7: pulse returns low
         out_nxt = 1'b0;
      end else if (cmp_hit) begin
         // R7: compare actions
         // R8: toggle actions
         unique case (mode)
            `CPW_M_SET: out_nxt = 1'b1;
            `CPW_M_CLR: out_nxt = 1'b0;
            `CPW_M_PULSE, `CPW_M_PULSECLR: out_nxt = 1'b1;
            `CPW_M_TGL, `CPW_M_TGLCLR: out_nxt = !out_r;
            default: out_nxt = out_r;
         endcase
      end
   end

   // Read data follow the next values so a read right after a write is fresh
   // R4: bit 6 reads zero
   // R3: bit 5 shows the output level
   wire [7:0] ctl_rd = {ctl_nxt.en, 1'b0, out_nxt, ctl_nxt.fmt, ctl_nxt.mode};
   wire [7:0] rd_val = (addr_lo == `CPW_OFS_CONTROL) ? ctl_rd :
                       (addr_lo == `CPW_OFS_TSEL) ? tsel_nxt :
                       (addr_lo == `CPW_OFS_LOW) ? low_nxt :
                       (addr_lo == `CPW_OFS_HIGH) ? high_nxt : 8'h00;

   // ************
   // Registers
   // ************
   // R1: every register back to its reset value
   always_ff @(posedge CLK) begin
      if (RST) begin
         ctl_r <= '0;
         tsel_r <= `CPW_RST_BYTE;
         low_r <= `CPW_RST_BYTE;
         high_r <= `CPW_RST_BYTE;
      end else if (CE) begin
         ctl_r <= ctl_nxt;
         tsel_r <= tsel_nxt;
         low_r <= low_nxt;
         high_r <= high_nxt;
      end
   end

   // Bus phase tracking and answers; never waits, always OKAY
   always_ff @(posedge CLK) begin
      if (RST) begin
         wr_pend_r <= 1'b0;
         rd_ctl_r <= 1'b0;
         addr_r <= 8'h00;
         hrdata_r <= 32'h00000000;
         hready_r <= 1'b1;
      end else if (CE) begin
         wr_pend_r <= addr_ok && HWRITE && mapped;
         rd_ctl_r <= addr_ok && !HWRITE && mapped && (addr_lo == `CPW_OFS_CONTROL);
         addr_r <= addr_lo;
         hrdata_r <= (addr_ok && !HWRITE && mapped) ? {24'h000000, rd_val} : 32'h00000000;
         hready_r <= 1'b1;
      end
   end

   // Capture input synchroniser; stage one feeds stage two only
   always_ff @(posedge CLK) begin
      if (RST) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         sync3_r <= 1'b0;
      end else if (CE) begin
         sync1_r <= UNIT_PIN_IN;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // Edge prescaler restarts on any control write
   always_ff @(posedge CLK) begin
      if (RST || (CE && (wr_ctl || mode == `CPW_M_OFF))) begin
         // R10: off clears the prescaler
         pre_r <= 4'h0;
      end else if (CE && edge_hit) begin
         pre_r <= pre_r + 4'h1;
      end
   end

   // Output, pulse and timer clear
   always_ff @(posedge CLK) begin
      if (RST) begin
         out_r <= 1'b0;
         pulse_r <= 1'b0;
         mprev_r <= 1'b0;
         cmp_clr_r <= 1'b0;
         pin_oe_r <= 1'b0;
         pwm_sig_r <= 1'b0;
      end else if (CE) begin
         out_r <= out_nxt;
         // R7: pulse lasts one cycle
         pulse_r <= cmp_hit && (mode == `CPW_M_PULSE || mode == `CPW_M_PULSECLR);
         mprev_r <= match;
         // R8: clear compare timer on match
         cmp_clr_r <= cmp_hit && (mode == `CPW_M_PULSECLR || mode == `CPW_M_TGLCLR);
         // R1: pin drives only when enabled as an output
         pin_oe_r <= en && (f_is_pwm(mode) || f_is_cmp(mode));
         // R17: PWM signal for internal consumers
         pwm_sig_r <= pwm_on && out_nxt;
      end
   end

   // Ports come straight from flops; HRESP is tied low
   assign HRDATA = hrdata_r;
   assign HREADYOUT = hready_r;
   assign HRESP = 1'b0;
   assign UNIT_PIN_OUT = out_r;
   assign UNIT_PIN_OE = pin_oe_r;
   assign COMPARE_CLEAR = cmp_clr_r;
   assign PWM_SIGNAL = pwm_sig_r;
   assign BASE_SELECT = tsel_r;

   // ************
   // Assertions
   // ************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   a_reset_pin_input: assert property ($past(RST) |-> !UNIT_PIN_OE && !UNIT_PIN_OUT) // R1
      else $error("pin not released after reset");
   a_ctl_bit6_zero: assert property (rd_ctl_r |-> HRDATA[`CPW_CTL_ZERO] == 1'b0) // R4
      else $error("control bit 6 read as one");
   a_ctl_out_level: assert property (rd_ctl_r |-> HRDATA[`CPW_CTL_OUT] == UNIT_PIN_OUT) // R3
      else $error("control bit 5 differs from output");
   a_off_drives_low: assert property (CE && mode == `CPW_M_OFF |=> !UNIT_PIN_OUT) // R10
      else $error("output high while off");
   a_set_on_match: assert property (CE && cmp_hit && mode == `CPW_M_SET |=> UNIT_PIN_OUT) // R7
      else $error("set on match missed");
   a_clr_on_match: assert property (CE && cmp_hit && mode == `CPW_M_CLR |=> !UNIT_PIN_OUT) // R7
      else $error("clear on match missed");
   a_pulse_shape: assert property (CE && cmp_hit && mode == `CPW_M_PULSE ##1 CE && cmp_on
      |-> UNIT_PIN_OUT ##1 !UNIT_PIN_OUT) // R7
      else $error("pulse not low-high-low");
   a_toggle_match: assert property (CE && cmp_hit && mode == `CPW_M_TGL
      |=> UNIT_PIN_OUT != $past(UNIT_PIN_OUT)) // R8
      else $error("toggle on match missed");
   a_timer_clear: assert property (CE && cmp_hit && mode == `CPW_M_TGLCLR
      |=> COMPARE_CLEAR ##1 (!COMPARE_CLEAR || !CE || $past(cmp_hit))) // R8
      else $error("compare timer clear missing");
   a_capture_load: assert property (CE && cap_evt
      |=> {high_r, low_r} == $past(COMPARE_TIMER)) // R13
      else $error("capture did not store timer");

   // Register and output checks
   a_disabled_released: assert property (CE && !en |=> !UNIT_PIN_OE) // R2
      else $error("pin driven while disabled");
   a_enable_stored: assert property (CE && wr_ctl |=> en == $past(wdat[`CPW_CTL_EN])) // R2
      else $error("enable bit not stored");
   a_pwm_sig_gated: assert property (CE && !pwm_on |=> !PWM_SIGNAL) // R17
      else $error("PWM signal high outside PWM mode");
   a_select_stored: assert property (CE && wr_tsel |=> BASE_SELECT == $past(wdat)) // R12
      else $error("time base select not stored");
   a_off_clears_pre: assert property (CE && mode == `CPW_M_OFF |=> pre_r == 4'h0) // R10
      else $error("prescaler kept counting while off");
   a_prescale_skip: assert property (CE && edge_hit && mode == `CPW_M_CAP_4 // R9
      && pre_r[1:0] != 2'h3 && !wr_low && !wr_high |=> $stable({high_r, low_r}))
      else $error("capture before fourth edge");
   // Three cycles without a base so the last live level has reached the pin
   a_reserved_frozen: assert property (CE && pwm_on && !base_ok // R22
      ##1 CE && pwm_on && !base_ok ##1 CE && pwm_on && !base_ok
      |-> $stable(UNIT_PIN_OUT))
      else $error("output moved without a time base");
   c_capture_seen: cover property (CE && cap_evt && mode == `CPW_M_CAP_16);
   c_pulse_seen: cover property (CE && cmp_hit && mode == `CPW_M_PULSECLR);
   c_pwm_high: cover property (PWM_SIGNAL ##1 !PWM_SIGNAL);
   c_ctl_read: cover property (rd_ctl_r && UNIT_PIN_OUT);
endmodule : cpw_unit
`default_nettype wire

// file: logic/cpw_consts.svh
// Offsets, field positions, reset values and mode codes of the unit
`ifndef CPW_CONSTS_SVH
`define CPW_CONSTS_SVH
// Register byte offsets on the bus
`define CPW_OFS_CONTROL 8'h00
`define CPW_OFS_TSEL 8'h04
`define CPW_OFS_LOW 8'h08
`define CPW_OFS_HIGH 8'h0C
// Control register field positions
`define CPW_CTL_EN 7
`define CPW_CTL_ZERO 6
`define CPW_CTL_OUT 5
`define CPW_CTL_FMT 4
// Reset value of every byte register
`define CPW_RST_BYTE 8'h00
// Mode codes
`define CPW_M_OFF 4'h0
`define CPW_M_TGLCLR 4'h1
`define CPW_M_TGL 4'h2
`define CPW_M_CAP_BOTH 4'h3
`define CPW_M_CAP_FALL 4'h4
`define CPW_M_CAP_RISE 4'h5
`define CPW_M_CAP_4 4'h6
`define CPW_M_CAP_16 4'h7
`define CPW_M_SET 4'h8
`define CPW_M_CLR 4'h9
`define CPW_M_PULSE 4'hA
`define CPW_M_PULSECLR 4'hB
`define CPW_M_PWM_TOP 2'h3
// Time base select codes
`define CPW_TSEL_RSVD 2'h3
// Edge prescaler terminal counts
`define CPW_PRE_4 4'h3
`define CPW_PRE_16 4'hF
`endif

// file: logic/cpw_pkg.sv
// Types shared by the unit and its PWM engine
package cpw_pkg;
   // One 8-bit timer as seen by a PWM engine
   typedef struct packed {
      logic inc;
      logic [7:0] period;
      logic [9:0] tbase;
   } cpw_base_t;
   // Writable control fields
   typedef struct packed {
      logic en;
      logic fmt;
      logic [3:0] mode;
   } cpw_ctl_t;
endpackage : cpw_pkg

// file: logic/cpw_pwm.sv
// PWM engine: period rollover, duty buffer and output level
`timescale 1ns/1ps
`default_nettype none
module cpw_pwm (
   // Clock and control
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic run,
   input wire logic off,
   // Time base and duty
   input wire cpw_pkg::cpw_base_t base,
   input wire logic [9:0] duty,
   // Level
   output logic lvl
);
   logic [9:0] buf_r;
   logic lvl_r;
   wire roll;
   wire over;
   wire hit;

   // R18: rollover from clock timebase
   assign roll = run && base.inc && (base.tbase[9:2] == base.period);
   assign over = duty > {base.period, 2'b11};
   assign hit = run && (base.tbase == buf_r);
   // R20: low already in the match cycle, so the high time equals the duty count
   assign lvl = lvl_r && !hit;

   // Duty buffer and level; mode off wipes both
   always_ff @(posedge clk) begin
      if (rst || (ce && off)) begin
         // R10: off resets state
         buf_r <= 10'h000;
         lvl_r <= 1'b0;
      end else if (ce) begin
         if (roll) begin
            // R19: latch duty at rollover
            buf_r <= duty;
         end
         // R21: oversize width holds level
         if (roll && !over) begin
            // R19: set unless zero duty
            lvl_r <= (duty != 10'h000);
         end else if (hit && !roll) begin
            // R20: clear on time base match
            lvl_r <= 1'b0;
         end
      end
   end

   // ************
   // Assertions
   // ************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_duty_latch_buf: assert property (ce && !off && roll |=> buf_r == $past(duty)) // R19
      else $error("duty not latched at rollover");
   a_zero_duty_low: assert property (ce && !off && roll && duty == 10'h000 |=> !lvl_r) // R19
      else $error("zero duty set the output");
   a_idle_holds_lvl: assert property (ce && !off && !run |=> $stable(lvl_r)) // R22
      else $error("level moved without a time base");
   c_roll_seen: cover property (ce && roll && duty != 10'h000);
endmodule : cpw_pwm
`default_nettype wire

// file: tb/cpw_timer_model.sv
// Partner model: three 8-bit PWM time bases on the system clock
`timescale 1ns/1ps
`default_nettype none
module cpw_timer_model #(
   parameter logic [7:0] PER [3] = '{8'h09, 8'h1F, 8'h3F}
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Time bases to the unit
   output var cpw_pkg::cpw_base_t [2:0] bases
);
   logic [1:0] ph_r;
   logic [7:0] cnt_r [3];
   // Prescale 1:1, so two clock phase bits extend each count to ten bits
   always_ff @(posedge clk) begin
      ph_r <= rst ? 2'h0 : ph_r + 2'h1;
      for (int i = 0; i < 3; i++) begin
         if (rst) begin
            cnt_r[i] <= 8'h00;
         end else if (ph_r == 2'h3) begin
            cnt_r[i] <= (cnt_r[i] == PER[i]) ? 8'h00 : cnt_r[i] + 8'h01;
         end
      end
   end
   // One shared phase, as timers fed from one clock source
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         bases[i].inc = (ph_r == 2'h3);
         bases[i].period = PER[i];
         bases[i].tbase = {cnt_r[i], ph_r};
      end
   end
endmodule : cpw_timer_model
`default_nettype wire

// file: tb/capture_compare_pwm_control_bench.sv
// Self-checking bench for the capture/compare/PWM unit
`timescale 1ns/1ps
`default_nettype none
`include "cpw_consts.svh"
module capture_compare_pwm_control_bench;
   localparam logic [7:0] PER [3] = '{8'h09, 8'h1F, 8'h3F};
   localparam logic [7:0] OFS [4] = '{`CPW_OFS_CONTROL, `CPW_OFS_TSEL, `CPW_OFS_LOW, `CPW_OFS_HIGH};
   // Control byte, level after match, clear pulse, level a cycle later
   localparam logic [10:0] CMP [7] = '{{8'h08, 3'h0}, {8'h88, 3'h5}, {8'h82, 3'h0},
      {8'h81, 3'h7}, {8'h89, 3'h0}, {8'h8A, 3'h4}, {8'h8B, 3'h6}};
   logic clk, rst, hsel, hwrite, pin_in, hreadyout, hresp, pin_out, pin_oe, cmp_clr, pwm_sig;
   logic lv, ce;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rd, junk;
   logic [15:0] ctmr, v, t;
   logic [7:0] base_sel, ctl;
   logic [9:0] d;
   cpw_pkg::cpw_base_t [2:0] tbases;
   logic [15:0] cap_q [$];
   int error_cnt, num_checks, seed, n, k, rise, full, hc, oc, ex, f;

   cpw_unit u_cpw_unit (.CLK(clk), .RST(rst), .CE(ce), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .COMPARE_TIMER(ctmr),
      .TIMER_BASE(tbases), .UNIT_PIN_IN(pin_in), .UNIT_PIN_OUT(pin_out),
      .UNIT_PIN_OE(pin_oe), .COMPARE_CLEAR(cmp_clr), .PWM_SIGNAL(pwm_sig),
      .BASE_SELECT(base_sel));
   cpw_timer_model u_cpw_timer_model (.clk(clk), .rst(rst), .bases(tbases));

   // ****************
   // Checking tasks
   // ****************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One single word transfer; waits on ready so no latency is assumed
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
      int m;
      m = 0;
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do begin @(posedge clk); m++; end while (hreadyout !== 1'b1 && m < 50);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin @(posedge clk); m++; end while (hreadyout !== 1'b1 && m < 50);
      rd = hrdata;
      if (m >= 50) error_cnt++;
      chk("response", 32'h0, 32'(hresp));
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      bus(a, 1'b1, wd);
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0);
      chk($sformatf("register %h", a), exp, rd);
   endtask : rdchk

   // High cycles over a window; an unknown level never counts as high
   task automatic count(input int len);
      hc = 0;
      oc = 0;
      repeat (len) begin
         @(posedge clk);
         hc += (pwm_sig === 1'b1);
         oc += (pin_out === 1'b1);
      end
   endtask : count

   task automatic chk_rst();
      foreach (OFS[i]) rdchk(OFS[i], 32'h0);
      chk("pins", 32'h0, 32'({pin_out, pin_oe, pwm_sig, cmp_clr, base_sel}));
   endtask : chk_rst

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report

   // ****************
   // Clock, watchdog
   // ****************
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Whole run is near 9k cycles, so this only trips on a hang
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      final_report();
   end

   // ****************
   // Tests
   // ****************
   initial begin
      {rst, hsel, hwrite, pin_in} = 4'h8;
      {htrans, haddr, hwdata, ctmr} = '0;
      ce = 1'b1;
      error_cnt = 0;
      num_checks = 0;
      seed = $urandom(32'h87554D1F);
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk_rst();
      wr(8'h10, 32'hFF);
      rdchk(8'h10, 32'h0);
      junk = $urandom;
      wr(OFS[1], junk);
      rdchk(OFS[1], {24'h0, junk[7:0]});
      chk("base select", {24'h0, junk[7:0]}, 32'(base_sel));
      wr(OFS[0], 32'h60);
      rdchk(OFS[0], 32'h0);
      $display("registers done");
      // Compare: one match per table row, timer leaves the value between rows
      v = 16'($urandom_range(16'hFFFE, 1));
      wr(OFS[2], 32'(v[7:0]));
      wr(OFS[3], 32'(v[15:8]));
      foreach (CMP[i]) begin
         ctl = CMP[i][10:3];
         wr(OFS[0], 32'(ctl));
         @(posedge clk);
         ctmr <= v;
         @(posedge clk);
         #1;
         chk("level", 32'(CMP[i][2]), 32'(pin_out));
         chk("clear", 32'(CMP[i][1]), 32'(cmp_clr));
         chk("enable", 32'(ctl[7]), 32'(pin_oe));
         @(posedge clk);
         #1;
         chk("after", 32'(CMP[i][0]), 32'(pin_out));
         chk("clear", 32'h0, 32'(cmp_clr));
         @(posedge clk);
         ctmr <= ~v;
         rdchk(OFS[0], {24'h0, ctl[7], 1'b0, CMP[i][0], ctl[4:0]});
      end
      $display("compare done");
      // Capture: random edge count per mode, model keeps every capture
      for (int m = 3; m < 8; m++) begin
         wr(OFS[2], 32'h0);
         wr(OFS[3], 32'h0);
         wr(OFS[0], 32'h80 | m);
         cap_q.delete();
         k = 0;
         n = $urandom_range(20, 1);
         for (int e = 0; e < 2 * n; e++) begin
            t = 16'($urandom);
            rise = (e % 2 == 0);
            k += rise;
            @(posedge clk);
            ctmr <= t;
            pin_in <= ~pin_in;
            if (m == 3 || (m == 4 && !rise) || (m == 5 && rise)
                || (m == 6 && rise && k % 4 == 0) || (m == 7 && rise && k % 16 == 0)) begin
               cap_q.push_back(t);
            end
            repeat (6) @(posedge clk);
         end
         v = (cap_q.size() > 0) ? cap_q[$] : 16'h0000;
         rdchk(OFS[2], 32'(v[7:0]));
         rdchk(OFS[3], 32'(v[15:8]));
         chk("enable", 32'h0, 32'(pin_oe));
      end
      $display("capture done");
      // PWM: each base, both layouts, duty zero, in range and past the period
      for (int r = 0; r < 18; r++) begin
         full = 4 * (PER[r % 3] + 1);
         f = (r / 3) % 2;
         junk = $urandom;
         d = (r < 6) ? 10'h0 : (r < 12) ? 10'($urandom_range(full - 1, 1)) : 10'(full);
         ex = (r < 6 || r >= 12) ? 0 : int'(d);
         wr(OFS[0], 32'h0);
         wr(OFS[1], {24'h0, junk[7:2], 2'(r % 3)});
         wr(OFS[2], f ? {24'h0, d[1:0], junk[13:8]} : {24'h0, d[7:0]});
         chk("off", 32'h0, 32'({pin_out, pin_oe, pwm_sig}));
         wr(OFS[3], f ? {24'h0, d[9:2]} : {24'h0, junk[21:16], d[9:8]});
         wr(OFS[0], {24'h0, 1'b1, 2'h0, 1'(f), 2'h3, 2'(r)});
         repeat (2 * full) @(posedge clk);
         count(full);
         chk("pwm high", ex, hc);
         chk("pin high", ex, oc);
      end
      // PWM on base one at duty 7F, so the holds below start from a live level
      wr(OFS[1], 32'h1);
      wr(OFS[2], 32'h7F);
      wr(OFS[3], 32'h0);
      wr(OFS[0], 32'h8C);
      repeat (300) @(posedge clk);
      // Clock enable low freezes the running PWM level
      ce <= 1'b0;
      repeat (2) @(posedge clk);
      lv = pwm_sig;
      count(64);
      chk("freeze", 32'(lv) * 64, hc);
      ce <= 1'b1;
      wr(OFS[1], 32'(`CPW_TSEL_RSVD));
      repeat (2) @(posedge clk);
      lv = pwm_sig;
      count(128);
      chk("hold", 32'(lv) * 128, hc);
      $display("pwm done");
      // Reset in mid-run
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk_rst();
      $display("reset done");
      final_report();
   end
endmodule : capture_compare_pwm_control_bench
`default_nettype wire
